// >>> eefrs_pkg.sv
// Purpose: Shared constants and types for the event five and fault reset block
// Assumes: APB slave with 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package eefrs_pkg;

	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_STATUS   = 12'h004;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;

	// Control word fields
	localparam int CTRL_EVSRC_LSB = 0;
	localparam int CTRL_EVSRC_W   = 3;
	localparam int CTRL_EVTYPE    = 4;
	localparam int CTRL_RSTSEL_LSB = 8;
	localparam int CTRL_RSTSEL_W   = 3;

	// Event source codes: 0 constant true (inactive), 1 constant false, 2..6 inputs
	localparam logic [2:0] EVSRC_TRUE  = 3'h0;
	localparam logic [2:0] EVSRC_FALSE = 3'h1;
	localparam logic [2:0] SEL_DI_BASE = 3'h2;
	localparam logic [2:0] SEL_DI_LAST = 3'h6;
	localparam logic [2:0] RSTSEL_RESET = 3'h0;
	localparam logic       EVTYPE_RESET = 1'b0;

	// Status and interrupt bits
	localparam int ST_FAULT   = 0;
	localparam int ST_WARNING = 1;
	localparam int ST_RESET   = 2;
	localparam int IRQ_W      = 3;

	typedef enum logic [0:0] {
		EEFRS_FAULT   = 1'b0,
		EEFRS_WARNING = 1'b1
	} eefrs_evtype_t;

	typedef struct packed {
		logic [2:0]    rst_sel;
		eefrs_evtype_t ev_type;
		logic [2:0]    ev_src;
	} eefrs_cfg_t;

	typedef struct packed {
		logic       remote_fb;
		logic       fb_reset;
		logic [4:0] di;
	} eefrs_in_t;

endpackage

// >>> eefrs_top.sv
// Purpose: External event five source/type and external fault reset selection
// Assumes: Inputs synchronous to I_CORE_CLK; APB slave, one wait state
// Notes:   Trip is held until a valid reset edge arrives with the cause gone
// Overview of operation
// - Event five source selectable, default constant true keeps it inactive.
// - Event five type: 0 raises a fault, 1 a warning; default fault.
// - Fault reset only on rising edge of selected source; default unused.
// - Reset edge clears trip only when the causing condition has gone.
// - Reset codes 0,1 none; 2..6 pick delayed digital inputs bits 0..4.
// - Fieldbus reset accepted whenever remote control is fully on fieldbus.
`timescale 1ns/1ps
module eefrs_top #(
	parameter int NUM_DI = 5
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic [4:0]  I_DI_DELAYED,
	input  wire logic        I_FB_RESET,
	input  wire logic        I_REMOTE_FB,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	output logic             O_FAULT,
	output logic             O_WARNING,
	output logic             O_IRQ
);

	// Selector codes map one to one onto five inputs
	if (NUM_DI != 5) begin : g_num_di_check
		$error("NUM_DI must be 5");
	end

	eefrs_pkg::eefrs_cfg_t cfg_q, cfg_d;
	eefrs_pkg::eefrs_in_t  in_now;
	logic [31:0]            prdata_q, prdata_d;
	logic                   pready_q, pready_d, pslverr_q, pslverr_d;
	logic [eefrs_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
	logic                   fault_q, fault_d, warn_q, warn_d, irq_q, irq_d;
	logic                   rst_src_q, fb_src_q;
	logic                   ev_src_val, ev_active, rst_src, rst_edge, fb_edge, reset_req;
	logic                   acc, wr, rd;

	assign in_now = '{remote_fb: I_REMOTE_FB, fb_reset: I_FB_RESET, di: I_DI_DELAYED};
	assign acc = I_PSEL && I_PENABLE && !pready_q;
	// Writes land at the edge where the master samples ready high
	assign wr  = I_PSEL && I_PENABLE && pready_q && I_PWRITE;
	assign rd  = acc && !I_PWRITE;

	// Event source decode; codes above the input range read as true
	always_comb begin
		ev_src_val = 1'b1;
		if (cfg_q.ev_src == eefrs_pkg::EVSRC_FALSE) begin
			ev_src_val = 1'b0;
		end else if (cfg_q.ev_src >= eefrs_pkg::SEL_DI_BASE &&
			cfg_q.ev_src <= eefrs_pkg::SEL_DI_LAST) begin
			ev_src_val = in_now.di[cfg_q.ev_src - eefrs_pkg::SEL_DI_BASE];
		end
		ev_active = !ev_src_val;
	end

	always_comb begin
		rst_src = 1'b0;
		if (cfg_q.rst_sel >= eefrs_pkg::SEL_DI_BASE &&
			cfg_q.rst_sel <= eefrs_pkg::SEL_DI_LAST) begin
			rst_src = in_now.di[cfg_q.rst_sel - eefrs_pkg::SEL_DI_BASE];
		end
		rst_edge  = rst_src && !rst_src_q;
		fb_edge   = in_now.remote_fb && in_now.fb_reset && !fb_src_q;
		reset_req = rst_edge || fb_edge;
	end

	// Trip logic: a reset edge is ignored while the cause stays present
	always_comb begin
		fault_d = fault_q;
		warn_d  = ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_WARNING;
		if (ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_FAULT) begin
			fault_d = 1'b1;
		end else if (reset_req) begin
			fault_d = 1'b0;
		end
	end

	always_comb begin
		cfg_d      = cfg_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		prdata_d   = '0;
		pslverr_d  = 1'b0;
		pready_d   = acc;
		// Unmapped offsets are refused in the first access cycle, either direction
		if (acc) begin
			case (I_PADDR)
				eefrs_pkg::OFF_CTRL, eefrs_pkg::OFF_STATUS,
				eefrs_pkg::OFF_IRQ_STAT, eefrs_pkg::OFF_IRQ_MASK: ;
				default: pslverr_d = 1'b1;
			endcase
		end
		if (wr) begin
			case (I_PADDR)
				eefrs_pkg::OFF_CTRL: begin
					cfg_d.ev_src  = I_PWDATA[eefrs_pkg::CTRL_EVSRC_LSB +: eefrs_pkg::CTRL_EVSRC_W];
					cfg_d.ev_type = eefrs_pkg::eefrs_evtype_t'(I_PWDATA[eefrs_pkg::CTRL_EVTYPE]);
					cfg_d.rst_sel = I_PWDATA[eefrs_pkg::CTRL_RSTSEL_LSB +: eefrs_pkg::CTRL_RSTSEL_W];
				end
				eefrs_pkg::OFF_IRQ_STAT: irq_stat_d = irq_stat_q & ~I_PWDATA[eefrs_pkg::IRQ_W-1:0];
				eefrs_pkg::OFF_IRQ_MASK: irq_mask_d = I_PWDATA[eefrs_pkg::IRQ_W-1:0];
				eefrs_pkg::OFF_STATUS: ;
				default: ;
			endcase
		end else if (rd) begin
			case (I_PADDR)
				eefrs_pkg::OFF_CTRL: begin
					prdata_d[eefrs_pkg::CTRL_EVSRC_LSB +: eefrs_pkg::CTRL_EVSRC_W] = cfg_q.ev_src;
					prdata_d[eefrs_pkg::CTRL_EVTYPE] = cfg_q.ev_type;
					prdata_d[eefrs_pkg::CTRL_RSTSEL_LSB +: eefrs_pkg::CTRL_RSTSEL_W] = cfg_q.rst_sel;
				end
				eefrs_pkg::OFF_STATUS: begin
					prdata_d[eefrs_pkg::ST_FAULT]   = fault_q;
					prdata_d[eefrs_pkg::ST_WARNING] = warn_q;
				end
				eefrs_pkg::OFF_IRQ_STAT: prdata_d[eefrs_pkg::IRQ_W-1:0] = irq_stat_q;
				eefrs_pkg::OFF_IRQ_MASK: prdata_d[eefrs_pkg::IRQ_W-1:0] = irq_mask_q;
				default: ;
			endcase
		end
		// Set after clear so a coincident event is kept
		if (fault_d && !fault_q) irq_stat_d[eefrs_pkg::ST_FAULT] = 1'b1;
		if (warn_d && !warn_q) irq_stat_d[eefrs_pkg::ST_WARNING] = 1'b1;
		if (fault_q && !fault_d) irq_stat_d[eefrs_pkg::ST_RESET] = 1'b1;
		irq_d = |(irq_stat_d & irq_mask_d);
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cfg_q      <= '{rst_sel: eefrs_pkg::RSTSEL_RESET,
				ev_type: eefrs_pkg::EEFRS_FAULT, ev_src: eefrs_pkg::EVSRC_TRUE};
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			prdata_q   <= 32'h0000_0000;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
			fault_q    <= 1'b0;
			warn_q     <= 1'b0;
			irq_q      <= 1'b0;
			rst_src_q  <= 1'b0;
			fb_src_q   <= 1'b0;
		end else begin
			cfg_q      <= cfg_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			prdata_q   <= prdata_d;
			pready_q   <= pready_d;
			pslverr_q  <= pslverr_d;
			fault_q    <= fault_d;
			warn_q     <= warn_d;
			irq_q      <= irq_d;
			rst_src_q  <= rst_src;
			fb_src_q   <= in_now.remote_fb && in_now.fb_reset;
		end
	end

	assign O_PRDATA  = prdata_q;
	assign O_PREADY  = pready_q;
	assign O_PSLVERR = pslverr_q;
	assign O_FAULT   = fault_q;
	assign O_WARNING = warn_q;
	assign O_IRQ     = irq_q;

	// Event, trip and reset behaviour
	a_fault_trip: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_FAULT) |=> O_FAULT)
		else $error("fault not tripped");

	a_warn_only: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_WARNING) |=> O_WARNING)
		else $error("warning not raised");

	a_default_quiet: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(cfg_q.ev_src == eefrs_pkg::EVSRC_TRUE) |-> !ev_active)
		else $error("inactive source asserted");

	a_level_noreset: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(O_FAULT && !reset_req) |=> O_FAULT)
		else $error("fault cleared without edge");

	a_cause_holds: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_FAULT && reset_req) |=> O_FAULT)
		else $error("trip cleared with cause present");

	a_edge_clears: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(O_FAULT && rst_edge && !ev_active) |=> !O_FAULT)
		else $error("reset edge ignored");

	a_sel_none: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(cfg_q.rst_sel < eefrs_pkg::SEL_DI_BASE) |-> !rst_edge)
		else $error("unused selector reset");

	a_fb_reset: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(O_FAULT && !ev_active && I_REMOTE_FB && I_FB_RESET && !$past(I_FB_RESET))
		|=> !O_FAULT)
		else $error("fieldbus reset ignored");

	a_false_src: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(cfg_q.ev_src == eefrs_pkg::EVSRC_FALSE) |-> ev_active)
		else $error("false source not active");

	a_di_src: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(cfg_q.ev_src >= eefrs_pkg::SEL_DI_BASE && cfg_q.ev_src <= eefrs_pkg::SEL_DI_LAST)
		|-> (ev_active == !I_DI_DELAYED[cfg_q.ev_src - eefrs_pkg::SEL_DI_BASE]))
		else $error("input source misread");

	a_warn_no_fault: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_WARNING && !O_FAULT) |=> !O_FAULT)
		else $error("warning type tripped fault");

	a_warn_drop: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!ev_active |=> !O_WARNING)
		else $error("warning without event");

	a_fault_no_warn: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_FAULT) |=> !O_WARNING)
		else $error("fault type raised warning");

	a_no_edge_low: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!rst_src |-> !rst_edge)
		else $error("reset edge on low source");

	a_no_fb_local: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!I_REMOTE_FB |-> !fb_edge)
		else $error("fieldbus reset outside remote");

	a_fb_level: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		fb_src_q |-> !fb_edge)
		else $error("fieldbus level gave reset");

	a_code7_none: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(cfg_q.rst_sel == 3'h7) |-> !rst_edge)
		else $error("code seven gave reset");

	a_no_spurious: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(!O_FAULT && !(ev_active && cfg_q.ev_type == eefrs_pkg::EEFRS_FAULT)) |=> !O_FAULT)
		else $error("fault without cause");

	a_clear_needs_req: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(O_FAULT ##1 !O_FAULT) |-> $past(reset_req))
		else $error("fault cleared without request");

	a_trip_from_cause: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(!O_FAULT ##1 O_FAULT) |-> $past(ev_active))
		else $error("trip without active event");

	a_warn_src_false: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(cfg_q.ev_src == eefrs_pkg::EVSRC_FALSE && cfg_q.ev_type == eefrs_pkg::EEFRS_WARNING)
		|=> O_WARNING)
		else $error("false source gave no warning");

	// Register bus and interrupt behaviour
	a_pready_pulse: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");

	a_ready_after_acc: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(I_PSEL && I_PENABLE && !O_PREADY) |=> O_PREADY)
		else $error("ready missing after access");

	a_no_ready_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!I_PSEL |=> !O_PREADY)
		else $error("ready without select");

	a_err_with_ready: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		O_PSLVERR |-> O_PREADY)
		else $error("error without ready");

	a_rdata_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!O_PREADY |-> (O_PRDATA == 32'h0000_0000))
		else $error("read data outside answer");

	a_err_no_data: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		O_PSLVERR |-> (O_PRDATA == 32'h0000_0000))
		else $error("data with error");

	a_no_write_early: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(I_PSEL && I_PENABLE && !O_PREADY) |=> $stable(cfg_q))
		else $error("write before ready");

	a_cfg_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!wr |=> $stable(cfg_q))
		else $error("config changed without write");

	a_mask_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!wr |=> $stable(irq_mask_q))
		else $error("mask changed without write");

	a_irq_level: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(|(irq_stat_q & irq_mask_q)) |-> O_IRQ)
		else $error("interrupt missing");

	a_stat_fault_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(!O_FAULT ##1 O_FAULT) |-> irq_stat_q[eefrs_pkg::ST_FAULT])
		else $error("fault status not set");

	a_stat_warn_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(!O_WARNING ##1 O_WARNING) |-> irq_stat_q[eefrs_pkg::ST_WARNING])
		else $error("warning status not set");

	a_stat_reset_set: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(O_FAULT ##1 !O_FAULT) |-> irq_stat_q[eefrs_pkg::ST_RESET])
		else $error("reset status not set");

	a_stat_sticky: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(irq_stat_q[eefrs_pkg::ST_FAULT] && !(wr && I_PADDR == eefrs_pkg::OFF_IRQ_STAT
		&& I_PWDATA[eefrs_pkg::ST_FAULT])) |=> irq_stat_q[eefrs_pkg::ST_FAULT])
		else $error("fault status lost");

endmodule

// >>> eefrs_src_model.sv
// Purpose: Far side: delayed digital inputs and fieldbus control word
// Assumes: Bench commands are registered once, like a delayed input status
// Notes:   Inputs idle high so that an event on an input stays inactive
`timescale 1ns/1ps
module eefrs_src_model (
	input  wire logic       i_clk,
	input  wire logic [4:0] i_di_cmd,
	input  wire logic       i_cw7_cmd,
	input  wire logic       i_remote_cmd,
	output logic      [4:0] o_di,
	output logic            o_fb_reset,
	output logic            o_remote_fb
);
	initial begin
		o_di = 5'h1f;
		o_fb_reset = 1'b0;
		o_remote_fb = 1'b0;
	end
	always @(posedge i_clk) begin
		o_di <= i_di_cmd;
		o_fb_reset <= i_cw7_cmd;
		o_remote_fb <= i_remote_cmd;
	end
endmodule

// >>> test_external_event_fault_reset_select.sv
// Purpose: Self-checking bench for event five and fault reset selection
// Assumes: APB answers within a few cycles
// Notes:   Ready and read data are taken at the rising edge; irq on the falling edge
`timescale 1ns/1ps
module test_external_event_fault_reset_select;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, fault, warn, irq, fbr, remfb;
	logic [4:0]  di_cmd = 5'h1f;
	logic [4:0]  di;
	logic        cw7 = 1'b0;
	logic        rem = 1'b0;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          j;
	always #50 clk = ~clk;
	eefrs_src_model far (.i_clk(clk), .i_di_cmd(di_cmd), .i_cw7_cmd(cw7), .i_remote_cmd(rem),
		.o_di(di), .o_fb_reset(fbr), .o_remote_fb(remfb));
	eefrs_top dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_DI_DELAYED(di),
		.I_FB_RESET(fbr), .I_REMOTE_FB(remfb), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_FAULT(fault), .O_WARNING(warn), .O_IRQ(irq));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Woken at the rise, before the design's update, so this is the sampled ready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		pen <= 1'b0;
		psel <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		wt(12);
		rst_n <= 1'b1;
		rdc(12'h000, 32'h0000_0000);
		rdc(12'h004, 32'h0000_0000);
		for (int k = 0; k < 5; k++) begin
			j = (k + 1) % 5;
			apb(1'b1, 12'h000, 32'((j + 2) << 8 | (k + 2)));
			di_cmd <= ~(5'h01 << k);
			wt(4);
			rdc(12'h004, 32'h0000_0001);
			di_cmd <= ~(5'h01 << k) & ~(5'h01 << j);
			wt(3);
			di_cmd <= ~(5'h01 << k);
			wt(3);
			rdc(12'h004, 32'h0000_0001);
			di_cmd <= ~(5'h01 << j);
			wt(3);
			rdc(12'h004, 32'h0000_0001);
			di_cmd <= 5'h1f;
			wt(3);
			rdc(12'h004, 32'h0000_0000);
		end
		rdc(12'h008, 32'h0000_0005);
		@(negedge clk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		apb(1'b1, 12'h00C, 32'h0000_0007);
		wt(2);
		@(negedge clk);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		apb(1'b1, 12'h008, 32'h0000_0005);
		rdc(12'h008, 32'h0000_0000);
		apb(1'b1, 12'h000, 32'h0000_0011);
		wt(3);
		rdc(12'h004, 32'h0000_0002);
		apb(1'b1, 12'h000, 32'h0000_0001);
		wt(3);
		apb(1'b1, 12'h000, 32'h0000_0000);
		rdc(12'h004, 32'h0000_0001);
		cw7 <= 1'b1;
		wt(3);
		cw7 <= 1'b0;
		wt(3);
		rdc(12'h004, 32'h0000_0001);
		rem <= 1'b1;
		wt(3);
		cw7 <= 1'b1;
		wt(3);
		rdc(12'h004, 32'h0000_0000);
		rdc(12'h010, 32'h0000_0000);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		end_sim();
	end
endmodule
